// >>> logic/mmd_cfg.svh
`ifndef MMD_CFG_SVH
`define MMD_CFG_SVH
// Register word indexes (haddr[9:2]) within the mapping block
`define MMD_OFS_RAM_POS     8'h10
`define MMD_OFS_REG_POS     8'h11
`define MMD_OFS_EE_POS      8'h12
`define MMD_OFS_MISC        8'h13
`define MMD_OFS_TEST0       8'h14
`define MMD_OFS_TEST1       8'h17
`define MMD_OFS_MSIZE_LO    8'h1c
`define MMD_OFS_MSIZE_HI    8'h1d
`define MMD_OFS_PAGE        8'h30
`define MMD_OFS_RSVD        8'h31
// Field positions and masks
`define MMD_BASE_MSB        7
`define MMD_BASE_LSB        3
`define MMD_RAM_MASK        8'hf9
`define MMD_REG_MASK        8'h78
`define MMD_EE_MASK         8'hf9
`define MMD_EE_BASE_MASK    8'hf8
`define MMD_EE_EN_MASK      8'h01
`define MMD_MISC_MASK       8'h0f
`define MMD_PAGE_MASK       8'h3f
// Reset values
`define MMD_RAM_RST         8'h08
`define MMD_REG_RST         8'h00
`define MMD_EE_RST          8'h01
`define MMD_MISC_RST        8'h0d
`define MMD_PAGE_RST        8'h00
// Register block window spans 2K bytes (addr[15:11])
`define MMD_REG_WIN_BITS    5
`endif

// >>> logic/mmd_pkg.sv
package mmd_pkg;
  // Operating mode of the core
  typedef enum logic [1:0] {
    MMD_MODE_NORMAL  = 2'b00,
    MMD_MODE_EMUL    = 2'b01,
    MMD_MODE_SPECIAL = 2'b10
  } mmd_mode_e;
  // Bus slave phase
  typedef enum logic [1:0] {
    MMD_ST_IDLE  = 2'b00,
    MMD_ST_WRITE = 2'b01,
    MMD_ST_READ  = 2'b10
  } mmd_state_e;
  typedef logic [7:0] mmd_byte_t;
endpackage

// >>> logic/mmd_once_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmd_cfg.svh"
module mmd_once_reg
  import mmd_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] ONCE_MASK = 8'hff,
  parameter logic [7:0] FREE_MASK = 8'h00
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       clk_en,
  // Write request
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       special,
  // Stored value
  output logic      [7:0] value
);
  logic written;

  // Write-once gating outside special modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value <= RESET_VAL;
    end else if (clk_en && wr_en) begin
      if (special || !written) begin
        value <= wr_data & (ONCE_MASK | FREE_MASK);
      end else begin
        value <= (value & ~FREE_MASK) | (wr_data & FREE_MASK);
      end
    end
  end

  // First write after reset is remembered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      written <= 1'b0;
    end else if (clk_en && wr_en) begin
      written <= 1'b1;
    end
  end

  AST_ONCE_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && wr_en && written && !special) |=> ((value & ~FREE_MASK) == $past(value & ~FREE_MASK)))
    else $error("locked bits changed");
  AST_SPECIAL_WR: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && wr_en && special) |=> (value == ($past(wr_data) & (ONCE_MASK | FREE_MASK))))
    else $error("special mode write lost");
endmodule
`default_nettype wire

// >>> logic/mmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmd_cfg.svh"
module mmd_decode
  import mmd_pkg::*;
(
  // Address and settings
  input  wire logic [15:0] addr,
  input  wire logic [4:0]  base,
  input  wire logic [4:0]  size_mask,
  input  wire logic        enable,
  // Select
  output logic             hit
);
  // Masked upper bits compared with base
  always_comb begin
    hit = enable && (((addr[15:11] ^ base) & size_mask) == 5'h00);
  end
endmodule
`default_nettype wire

// >>> logic/mmd_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmd_cfg.svh"
// Notes on behaviour
// - RAM position written once unless special mode or op_mode 3
// - Register position written once unless special or op_mode 3
// - Decode follows position writes one cycle later
// - RAM base field gives address bits 15:11
// - RAM alignment bit only forces base bits that RAM_MASK5 masks out, so it has no effect on the decode
// - Register block on 2K boundary, low 32K
// - Register base bit 7 always zero
// - Map registers decoded from hsel and haddr[9:2] only, not moved by register base
// - EEPROM enable always writable; base per parameter
// - EEPROM base field gives address bits 15:11
// - EEPROM enable removes or places EEPROM
// - EEPROM reset value is a parameter
// - Size input picks 1K or 2K registers
module mmd_map
  import mmd_pkg::*;
#(
  parameter logic [7:0] EE_RESET     = `MMD_EE_RST,
  parameter logic       EE_BASE_ONCE = 1'b0,
  parameter logic [4:0] RAM_MASK5    = 5'h1f,
  parameter logic [4:0] EE_MASK5     = 5'h1f,
  parameter logic [7:0] TEST0_VAL    = 8'h00,
  parameter logic [7:0] TEST1_VAL    = 8'h00,
  parameter logic [7:0] MSIZE_HI_VAL = 8'h00
) (
  // Clock, reset and enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Configuration
  input  wire logic [1:0]  op_mode,
  input  wire logic        register_space_size_switch,
  input  wire logic [6:0]  msize_lo_rest,
  // Core address and selects
  input  wire logic [15:0] core_addr,
  output logic             ram_sel,
  output logic             reg_sel,
  output logic             ee_sel,
  output logic [7:0]       misc_ctrl,
  output logic [5:0]       program_page_index
);
  // ***************************************************************
  // Bus slave
  // ***************************************************************
  mmd_state_e state;
  logic [7:0] word_idx;
  logic [7:0] ram_position;
  logic [7:0] register_block_position;
  logic [7:0] eeprom_position;
  logic [7:0] misc_reg;
  logic [7:0] next_rdata;
  logic       special;
  logic       wr_ram;
  logic       wr_reg;
  logic       wr_ee;
  logic       ram_hit;
  logic       reg_hit;
  logic       ee_hit;
  logic [4:0] reg_mask5;
  logic [4:0] ram_base;

  assign special = (op_mode == MMD_MODE_SPECIAL);

  // Address phase capture, byte offset taken as word index times four
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= MMD_ST_IDLE;
      word_idx <= 8'h00;
    end else if (clk_en) begin
      if (hsel && hready && htrans[1]) begin
        state    <= hwrite ? MMD_ST_WRITE : MMD_ST_READ;
        word_idx <= haddr[9:2];
      end else if (hready) begin
        state    <= MMD_ST_IDLE;
      end
    end
  end

  // Register write strobes in the data phase
  always_comb begin
    wr_ram = clk_en && (state == MMD_ST_WRITE) && (word_idx == `MMD_OFS_RAM_POS);
    wr_reg = clk_en && (state == MMD_ST_WRITE) && (word_idx == `MMD_OFS_REG_POS);
    wr_ee  = clk_en && (state == MMD_ST_WRITE) && (word_idx == `MMD_OFS_EE_POS);
  end

  // ***************************************************************
  // Position registers
  // ***************************************************************
  mmd_once_reg #(
    .RESET_VAL (`MMD_RAM_RST),
    .ONCE_MASK (`MMD_RAM_MASK),
    .FREE_MASK (8'h00)
  ) u_ram_pos (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .wr_en   (wr_ram),
    .wr_data (hwdata[7:0]),
    .special (special || (op_mode == 2'b11)),
    .value   (ram_position)
  );

  // Bit 7 masked off so the block stays in the low 32K
  mmd_once_reg #(
    .RESET_VAL (`MMD_REG_RST),
    .ONCE_MASK (`MMD_REG_MASK),
    .FREE_MASK (8'h00)
  ) u_reg_pos (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .wr_en   (wr_reg),
    .wr_data (hwdata[7:0]),
    .special (special || (op_mode == 2'b11)),
    .value   (register_block_position)
  );

  // Base bits once or free by parameter, enable bit always free
  mmd_once_reg #(
    .RESET_VAL (EE_RESET),
    .ONCE_MASK (EE_BASE_ONCE ? `MMD_EE_BASE_MASK : 8'h00),
    .FREE_MASK (EE_BASE_ONCE ? `MMD_EE_EN_MASK : `MMD_EE_MASK)
  ) u_ee_pos (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .wr_en   (wr_ee),
    .wr_data (hwdata[7:0]),
    .special (special || (op_mode == 2'b11)),
    .value   (eeprom_position)
  );

  // Miscellaneous control and page index
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      misc_reg           <= `MMD_MISC_RST;
      program_page_index <= 6'h00;
    end else if (clk_en && state == MMD_ST_WRITE) begin
      if (word_idx == `MMD_OFS_MISC) begin
        misc_reg <= hwdata[7:0] & `MMD_MISC_MASK;
      end
      if (word_idx == `MMD_OFS_PAGE) begin
        program_page_index <= hwdata[5:0];
      end
    end
  end

  // Read multiplexer on the address phase index, unmapped reads as zero
  always_comb begin
    case (haddr[9:2])
      `MMD_OFS_RAM_POS:  next_rdata = ram_position;
      `MMD_OFS_REG_POS:  next_rdata = register_block_position;
      `MMD_OFS_EE_POS:   next_rdata = eeprom_position;
      `MMD_OFS_MISC:     next_rdata = misc_reg;
      `MMD_OFS_TEST0:    next_rdata = TEST0_VAL;
      `MMD_OFS_TEST1:    next_rdata = TEST1_VAL;
      `MMD_OFS_MSIZE_LO: next_rdata = {register_space_size_switch, msize_lo_rest};
      `MMD_OFS_MSIZE_HI: next_rdata = MSIZE_HI_VAL;
      `MMD_OFS_PAGE:     next_rdata = {2'b00, program_page_index};
      default:           next_rdata = 8'h00;
    endcase
  end

  // Read data loaded at the address phase edge, stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hsel && hready && htrans[1] && !hwrite) begin
        hrdata <= {24'h00_0000, next_rdata};
      end
    end
  end

  // ***************************************************************
  // Address decode
  // ***************************************************************
  // Register block size: 1K keeps addr[10] out, handled by the decoder enable, window mask stays full
  always_comb begin
    reg_mask5 = 5'h1f;
    ram_base  = ram_position[7:3];
    if (ram_position[0]) begin
      ram_base = ram_position[7:3] | ~RAM_MASK5;
    end else begin
      ram_base = ram_position[7:3] & RAM_MASK5;
    end
  end

  mmd_decode u_dec_ram (
    .addr      (core_addr),
    .base      (ram_base),
    .size_mask (RAM_MASK5),
    .enable    (1'b1),
    .hit       (ram_hit)
  );

  mmd_decode u_dec_reg (
    .addr      (core_addr),
    .base      ({1'b0, register_block_position[6:3]}),
    .size_mask (reg_mask5),
    .enable    (register_space_size_switch || !core_addr[10]),
    .hit       (reg_hit)
  );

  mmd_decode u_dec_ee (
    .addr      (core_addr),
    .base      (eeprom_position[7:3]),
    .size_mask (EE_MASK5),
    .enable    (eeprom_position[0]),
    .hit       (ee_hit)
  );

  // Selects registered: a position write takes effect next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ram_sel   <= 1'b0;
      reg_sel   <= 1'b0;
      ee_sel    <= 1'b0;
      misc_ctrl <= `MMD_MISC_RST;
    end else if (clk_en) begin
      reg_sel   <= reg_hit;
      ram_sel   <= ram_hit && !reg_hit;
      ee_sel    <= ee_hit && !reg_hit && !ram_hit;
      misc_ctrl <= misc_reg;
    end
  end

  AST_REG_LOW32K: assert property (@(posedge hclk) disable iff (!hresetn)
    register_block_position[7] == 1'b0)
    else $error("register base left low 32K");
  AST_EE_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && !eeprom_position[0]) |=> !ee_sel)
    else $error("eeprom selected while disabled");
  AST_REG_SEL: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && core_addr[15] && register_space_size_switch) |=> !reg_sel)
    else $error("register block hit above 32K");
  AST_EE_HIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && eeprom_position[0] && (core_addr[15:11] == eeprom_position[7:3])
     && !reg_hit && !ram_hit && EE_MASK5 == 5'h1f) |=> ee_sel)
    else $error("eeprom base miss");
  AST_RAM_HIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && RAM_MASK5 == 5'h1f && core_addr[15:11] == ram_position[7:3]
     && !reg_hit) |=> ram_sel)
    else $error("ram base miss");
  AST_REG_1K: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && !register_space_size_switch && core_addr[10]) |=> !reg_sel)
    else $error("1K register block hit upper half");
  AST_DELAY: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && wr_ee) |=> (ee_sel == $past(ee_hit && !reg_hit && !ram_hit)))
    else $error("decode not one cycle after write");
  AST_READY: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("slave not ready");
endmodule
`default_nettype wire

// >>> tb/mmd_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Core side model
// ****************
module mmd_core_model (
  // Clock
  input  wire logic        hclk,
  // Decode results
  input  wire logic        ram_sel,
  input  wire logic        reg_sel,
  input  wire logic        ee_sel,
  // Address to decode
  output logic      [15:0] core_addr
);
  // Park on an address outside every reset window
  initial core_addr = 16'hf000;

  // Present an address, let the registered selects follow, sample them settled
  task automatic probe(input logic [15:0] a, output logic [2:0] s);
    @(posedge hclk);
    core_addr <= a;
    @(posedge hclk);
    @(negedge hclk);
    s = {reg_sel, ram_sel, ee_sel};
  endtask
endmodule
`default_nettype wire

// >>> tb/test_memory_map_position_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bench
// ****************
module test_memory_map_position_decode
  import mmd_pkg::*;
;
  localparam logic [7:0]  EE_RST = 8'h41;
  localparam logic [31:0] A_RAM  = 32'h0000_0040;
  localparam logic [31:0] A_REG  = 32'h0000_0044;
  localparam logic [31:0] A_EE   = 32'h0000_0048;
  localparam logic [31:0] A_MISC = 32'h0000_004c;
  localparam logic [31:0] A_T0   = 32'h0000_0050;
  localparam logic [31:0] A_MLO  = 32'h0000_0070;
  localparam logic [31:0] A_PG   = 32'h0000_00c0;
  localparam logic [31:0] A_RSV  = 32'h0000_00c4;

  // Stimulus and observed signals
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        clk_en  = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0000_0000;
  logic [1:0]  htrans  = 2'b00;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'b010;
  logic        hready;
  logic [31:0] hwdata  = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  op_mode = 2'b00;
  logic        register_space_size_switch = 1'b1;
  logic [6:0]  msize_lo_rest = 7'h33;
  logic [15:0] core_addr;
  logic        ram_sel;
  logic        reg_sel;
  logic        ee_sel;
  logic [7:0]  misc_ctrl;
  logic [5:0]  program_page_index;
  int          fails = 0;
  int          samples_checked = 0;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  // Clock
  always #12.5 hclk = ~hclk;

  mmd_map #(
    .EE_RESET  (EE_RST),
    .TEST0_VAL (8'h5a)
  ) i_dut (
    .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready, .hwdata, .hrdata, .hreadyout, .hresp, .op_mode,
    .register_space_size_switch, .msize_lo_rest, .core_addr, .ram_sel,
    .reg_sel, .ee_sel, .misc_ctrl, .program_page_index
  );

  mmd_core_model i_core (
    .hclk, .ram_sel, .reg_sel, .ee_sel, .core_addr
  );

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait for ready, sampled at a falling edge, bounded to 20 cycles
  task automatic wait_rdy(output logic [31:0] q);
    logic r;
    int   n;
    n = 0;
    do begin
      @(negedge hclk);
      r = hreadyout;
      q = hrdata;
      @(posedge hclk);
      n++;
    end while (r !== 1'b1 && n < 20);
    if (r !== 1'b1) begin
      fails++;
      end_sim();
    end
  endtask

  // One single word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy(q);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy(q);
  endtask

  // Register write, register read with compare, decode probe with compare
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, {24'h00_0000, d}, q);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, {24'h00_0000, e});
  endtask
  task automatic sel(input logic [15:0] a, input logic [2:0] e);
    logic [2:0] s;
    i_core.probe(a, s);
    chk({29'h0000_0000, s}, {29'h0000_0000, e});
  endtask

  // Reset into a given mode
  task automatic do_reset(input logic [1:0] m);
    @(posedge hclk);
    hresetn <= 1'b0;
    op_mode <= m;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  // Main sequence
  initial begin
    do_reset(2'b00);
    rd(A_RAM, 8'h08);
    rd(A_REG, 8'h00);
    rd(A_EE, EE_RST);
    rd(A_MISC, 8'h0d);
    rd(A_MLO, 8'hb3);
    wr(A_T0, 8'hff);
    rd(A_T0, 8'h5a);
    wr(A_RSV, 8'hff);
    rd(A_RSV, 8'h00);
    wr(A_PG, 8'hff);
    rd(A_PG, 8'h3f);
    chk({26'h000_0000, program_page_index}, 32'h0000_003f);
    wr(A_MISC, 8'hff);
    repeat (2) @(negedge hclk);
    chk({24'h00_0000, misc_ctrl}, 32'h0000_000f);
    // Write-once versus free writes in every mode
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1:0]);
      wr(A_RAM, 8'h20);
      wr(A_RAM, 8'h38);
      rd(A_RAM, m[1] ? 8'h38 : 8'h20);
      wr(A_REG, 8'hff);
      wr(A_REG, 8'h10);
      rd(A_REG, m[1] ? 8'h10 : 8'h78);
      wr(A_EE, 8'h30);
      wr(A_EE, 8'h51);
      rd(A_EE, 8'h51);
    end
    // Decode windows: RAM 0x3800, registers 0x1000, EEPROM 0x5000
    sel(16'h3800, 3'b010);
    sel(16'h3fff, 3'b010);
    sel(16'h4000, 3'b000);
    sel(16'h1000, 3'b100);
    sel(16'h17ff, 3'b100);
    sel(16'h5000, 3'b001);
    sel(16'h5800, 3'b000);
    @(posedge hclk);
    register_space_size_switch <= 1'b0;
    sel(16'h17ff, 3'b000);
    sel(16'h13ff, 3'b100);
    // RAM moved over the register window: registers win
    wr(A_RAM, 8'h10);
    sel(16'h1000, 3'b100);
    sel(16'h1400, 3'b010);
    // Enable off, then on with the decode lagging one cycle
    wr(A_EE, 8'h50);
    sel(16'h5000, 3'b000);
    wr(A_EE, 8'h51);
    @(negedge hclk);
    chk({31'h0000_0000, ee_sel}, 32'h0000_0000);
    @(negedge hclk);
    chk({31'h0000_0000, ee_sel}, 32'h0000_0001);
    end_sim();
  end
endmodule
`default_nettype wire
